// >>> mic_consts.svh
`ifndef MIC_CONSTS_SVH
`define MIC_CONSTS_SVH

// register byte offsets on the wishbone slave
`define MIC_OFS_REQ_HIGH 5'h00
`define MIC_OFS_REQ_LOW 5'h04
`define MIC_OFS_EN_HIGH 5'h08
`define MIC_OFS_EN_LOW 5'h0c
`define MIC_OFS_EDGE_SEL 5'h10
`define MIC_OFS_PSW 5'h14
`define MIC_OFS_SP 5'h18

// reset values
`define MIC_RST_BYTE 8'h00
`define MIC_RST_SP 8'hff

// status word fields
`define MIC_PSW_IFLAG 2
`define MIC_PSW_BFLAG 4

// edge modes, two bits per pin in the edge select register
`define MIC_EDGE_NONE 2'h0
`define MIC_EDGE_FALL 2'h1
`define MIC_EDGE_RISE 2'h2
`define MIC_EDGE_BOTH 2'h3

// source index, in falling priority order
`define MIC_SRC_EXT0 3'h0
`define MIC_SRC_EXT1 3'h1
`define MIC_NUM_SRC 8

// memory map seen by the acceptance sequence
`define MIC_STACK_PAGE 8'h01
`define MIC_VEC_BASE 16'hffe0
`define MIC_VEC_BREAK 16'hffde

`endif

// >>> mic_pkg.sv
package mic_pkg;
  typedef enum logic [3:0] {
    MIC_IDLE,
    MIC_A_CLR,
    MIC_A_PCH,
    MIC_A_PCL,
    MIC_A_PSW,
    MIC_A_VL,
    MIC_A_VH,
    MIC_A_CAP,
    MIC_A_JMP,
    MIC_R_PSW,
    MIC_R_PCL,
    MIC_R_PCH,
    MIC_R_CAP,
    MIC_R_JMP
  } mic_state_t;
endpackage

// >>> mic_edge_detect.sv
`timescale 1ns/10ps
`default_nettype none
`include "mic_consts.svh"

module mic_edge_detect (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // pin and mode
  input wire logic pin_i,
  input wire logic [1:0] mode_i,
  // detected transition
  output logic edge_o
);

  logic prev;
  wire fell = prev & ~pin_i;
  wire rose = ~prev & pin_i;

  // pin is already synchronous, so one history flop is enough
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      prev <= 1'b0;
    end else begin
      prev <= pin_i;
    end
  end

  // mode picks falling, rising, both or none
  assign edge_o = ((mode_i == `MIC_EDGE_FALL) & fell) |
                  ((mode_i == `MIC_EDGE_RISE) & rose) |
                  ((mode_i == `MIC_EDGE_BOTH) & (fell | rose)); // see RULE1

endmodule

`default_nettype wire

// >>> mic_irq_ctrl.sv
// Behaviour
// RULE1: each external pin requests on a falling or rising edge as selected.
// RULE2: hardware clears an external pin flag when its vector is taken.
// RULE3: software clears every other flag after acceptance.
// RULE4: timer flags set on counter compare match.
// RULE5: interval timer flag sets on counter overflow.
// RULE6: converter flag sets when a conversion finishes.
// RULE7: watchdog flags set on watchdog compare match.
// RULE8: accept only with flag, own enable and master enable bit 2 set.
// RULE9: zero enable never accepted; master enable clear blocks all maskable.
// RULE10: fixed order ext0, ext1, timer0, timer1, converter, watchdog, interval.
// RULE11: flag stays pending until accepted, reset or written clear.
// RULE12: acceptance starts at instruction end and lasts 8 cycles.
// RULE13: accepting a maskable request first clears master enable.
// RULE14: after a non-maskable acceptance further requests wait briefly.
// RULE15: push return high, low, status word; stack pointer drops three.
// RULE16: fetch two-byte vector, load program counter, run from there.
// RULE17: master enable clear blocks even higher priority requests.
// RULE18: software sets master enable to nest and picks sources by enables.
// RULE19: return instruction ends the service and resumes the program.
// RULE20: software break has the lowest priority of all.
// RULE21: break shares table call zero vector and sets the break flag.
// RULE22: higher priority wins among simultaneous requests by fixed polling.
// RULE23: return pops status and address, stack pointer rises three.
`timescale 1ns/10ps
`default_nettype none
`include "mic_consts.svh"

module mic_irq_ctrl
  import mic_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // external pins
  input wire logic ext_irq_pin0_i,
  input wire logic ext_irq_pin1_i,
  // peripheral events, one-cycle pulses
  input wire logic timer0_match_i,
  input wire logic timer1_match_i,
  input wire logic interval_ovf_i,
  input wire logic converter_done_i,
  input wire logic watchdog_match_i,
  input wire logic watch_timer_match_i,
  // core instruction boundary
  input wire logic instr_done_i,
  input wire logic soft_break_instr_i,
  input wire logic irq_return_instr_i,
  input wire logic irq_enable_instr_i,
  input wire logic [15:0] pc_i,
  // core memory port
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic mem_we_o,
  output logic mem_re_o,
  input wire logic [7:0] mem_rdata_i,
  // core control
  output logic busy_o,
  output logic pc_load_o,
  output logic [15:0] pc_o,
  output logic [7:0] psw_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  mic_state_t state;
  logic [7:0] flags;
  logic [7:0] enables;
  logic [3:0] edge_sel;
  logic [7:0] program_status_word;
  logic [7:0] sp;
  logic [7:0] saved_psw;
  logic [15:0] saved_pc;
  logic [15:0] vec_addr;
  logic [7:0] vec_lo;
  logic [2:0] src;
  logic is_break;
  logic brk_pending;
  logic inhibit;

  ////////////////////////////////////////////////////////////////////////////
  // edge detectors for the two external pins

  logic ext0_edge;
  logic ext1_edge;

  mic_edge_detect u_edge0 (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pin_i(ext_irq_pin0_i),
    .mode_i(edge_sel[1:0]),
    .edge_o(ext0_edge)
  );

  mic_edge_detect u_edge1 (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pin_i(ext_irq_pin1_i),
    .mode_i(edge_sel[3:2]),
    .edge_o(ext1_edge)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire [7:0] wr_byte = wb_dat_i[7:0];
  wire sel_req_h = (wb_adr_i == `MIC_OFS_REQ_HIGH);
  wire sel_req_l = (wb_adr_i == `MIC_OFS_REQ_LOW);
  wire sel_en_h = (wb_adr_i == `MIC_OFS_EN_HIGH);
  wire sel_en_l = (wb_adr_i == `MIC_OFS_EN_LOW);
  wire sel_edge = (wb_adr_i == `MIC_OFS_EDGE_SEL);
  wire sel_psw = (wb_adr_i == `MIC_OFS_PSW);
  wire sel_sp = (wb_adr_i == `MIC_OFS_SP);

  // register bytes: high group holds sources 0..3, low group 4..7
  wire [7:0] req_high = {flags[0], flags[1], flags[2], flags[3], 4'h0};
  wire [7:0] req_low = {flags[4], flags[5], flags[6], flags[7], 4'h0};
  wire [7:0] en_high = {enables[0], enables[1], enables[2], enables[3], 4'h0};
  wire [7:0] en_low = {enables[4], enables[5], enables[6], enables[7], 4'h0};

  // unmapped offsets read zero and still get an ack
  wire [7:0] rd_byte = sel_req_h ? req_high :
                       sel_req_l ? req_low :
                       sel_en_h ? en_high :
                       sel_en_l ? en_low :
                       sel_edge ? {4'h0, edge_sel} :
                       sel_psw ? program_status_word :
                       sel_sp ? sp : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // request flags: hardware set beats both clears in the same cycle

  wire [7:0] hw_set = {interval_ovf_i, // see RULE5
                       watch_timer_match_i,
                       watchdog_match_i, // see RULE7
                       converter_done_i, // see RULE6
                       timer1_match_i,
                       timer0_match_i, // see RULE4
                       ext1_edge,
                       ext0_edge}; // see RULE1

  wire [7:0] sw_flags = bus_wr & sel_req_h ?
                        {flags[7:4], wr_byte[4], wr_byte[5], wr_byte[6],
                         wr_byte[7]} :
                        bus_wr & sel_req_l ?
                        {wr_byte[4], wr_byte[5], wr_byte[6], wr_byte[7],
                         flags[3:0]} : flags;

  // only the edge-triggered pins are cleared by the sequence
  wire vec_now = (state == MIC_A_JMP) & ~is_break;
  wire [7:0] hw_clr = {6'h00,
                       vec_now & (src == `MIC_SRC_EXT1),
                       vec_now & (src == `MIC_SRC_EXT0)}; // see RULE2

  // other flags are left for the service routine to clear
  wire [7:0] next_flags = (sw_flags & ~hw_clr) | hw_set; // see RULE3, RULE11

  wire [7:0] next_enables = bus_wr & sel_en_h ?
                            {enables[7:4], wr_byte[4], wr_byte[5],
                             wr_byte[6], wr_byte[7]} :
                            bus_wr & sel_en_l ?
                            {wr_byte[4], wr_byte[5], wr_byte[6], wr_byte[7],
                             enables[3:0]} : enables;

  ////////////////////////////////////////////////////////////////////////////
  // priority resolution

  wire master_en = program_status_word[`MIC_PSW_IFLAG];
  wire [7:0] eligible = flags & enables & {8{master_en}}; // see RULE8, RULE9

  logic [2:0] win_idx;
  logic win_any;

  // lowest index wins: fixed polling order from ext0 down to interval
  always_comb begin
    win_idx = 3'h0;
    win_any = 1'b0;
    for (int i = `MIC_NUM_SRC - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        win_idx = 3'(i); // see RULE10, RULE22
        win_any = 1'b1;
      end
    end
  end

  // break raised by the instruction just finished, or waiting behind a
  // maskable one or an inhibited boundary; maskable requests go first
  wire brk_req = brk_pending | (instr_done_i & soft_break_instr_i);
  wire at_boundary = instr_done_i & (state == MIC_IDLE);
  wire take_mask = at_boundary & ~inhibit & win_any; // see RULE17, RULE12
  wire take_brk = at_boundary & ~inhibit & ~win_any & brk_req; // see RULE20
  wire take_ret = at_boundary & irq_return_instr_i & ~take_mask & ~take_brk;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  mic_state_t next_state;

  always_comb begin
    next_state = state;
    unique case (state)
      MIC_IDLE: begin
        if (take_mask | take_brk) begin
          next_state = MIC_A_CLR;
        end else if (take_ret) begin
          next_state = MIC_R_PSW; // see RULE19
        end
      end
      MIC_A_CLR: next_state = MIC_A_PCH;
      MIC_A_PCH: next_state = MIC_A_PCL;
      MIC_A_PCL: next_state = MIC_A_PSW;
      MIC_A_PSW: next_state = MIC_A_VL;
      MIC_A_VL: next_state = MIC_A_VH;
      MIC_A_VH: next_state = MIC_A_CAP;
      MIC_A_CAP: next_state = MIC_A_JMP;
      MIC_A_JMP: next_state = MIC_IDLE;
      MIC_R_PSW: next_state = MIC_R_PCL;
      MIC_R_PCL: next_state = MIC_R_PCH;
      MIC_R_PCH: next_state = MIC_R_CAP;
      MIC_R_CAP: next_state = MIC_R_JMP;
      MIC_R_JMP: next_state = MIC_IDLE;
    endcase
  end

  // memory strobes are registered from the next state, so they line up with the state they belong to
  wire nx_push = (next_state == MIC_A_PCH) | (next_state == MIC_A_PCL) |
                 (next_state == MIC_A_PSW);
  wire nx_vec = (next_state == MIC_A_VL) | (next_state == MIC_A_VH);
  wire nx_pop = (next_state == MIC_R_PSW) | (next_state == MIC_R_PCL) |
                (next_state == MIC_R_PCH);
  wire [7:0] sp_dn = sp - 8'h01;
  wire [7:0] sp_up = sp + 8'h01;

  // pushed status word carries the master enable from before the clear
  wire [7:0] next_wdata = (next_state == MIC_A_PCH) ? saved_pc[15:8] :
                          (next_state == MIC_A_PCL) ? saved_pc[7:0] :
                          saved_psw; // see RULE15
  wire [15:0] next_addr = nx_push ? {`MIC_STACK_PAGE, sp} :
                          nx_pop ? {`MIC_STACK_PAGE, sp_up} :
                          (next_state == MIC_A_VH) ? vec_addr + 16'h0001 :
                          vec_addr;

  // vector: the break shares the table call zero slot
  wire [15:0] next_vec = take_brk ? `MIC_VEC_BREAK :
                         `MIC_VEC_BASE + {12'h000, win_idx, 1'b0}; // see RULE21

  ////////////////////////////////////////////////////////////////////////////
  // status word: sequencer first, then enable instruction, then the bus

  logic [7:0] next_psw;

  always_comb begin
    next_psw = program_status_word;
    if (bus_wr & sel_psw) begin
      next_psw = wr_byte;
    end
    if (instr_done_i & irq_enable_instr_i) begin
      next_psw[`MIC_PSW_IFLAG] = 1'b1; // see RULE18
    end
    if (state == MIC_A_CLR) begin
      next_psw[`MIC_PSW_IFLAG] = 1'b0; // see RULE13
      next_psw[`MIC_PSW_BFLAG] = is_break; // see RULE21
    end
    if (state == MIC_R_CAP) begin
      next_psw = saved_psw; // see RULE23
    end
  end

  // stack pointer steps at the same edge that issues each push or pop
  // address, so back to back accesses land on neighbouring bytes; the bus
  // may load it in any cycle that issues no push or pop
  wire [7:0] next_sp = nx_push ? sp_dn : // see RULE15
                       nx_pop ? sp_up : // see RULE23
                       (bus_wr & sel_sp) ? wr_byte : sp;

  ////////////////////////////////////////////////////////////////////////////
  // control registers and bus answer

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flags <= `MIC_RST_BYTE;
      enables <= `MIC_RST_BYTE;
      edge_sel <= 4'h0;
      program_status_word <= `MIC_RST_BYTE;
      sp <= `MIC_RST_SP;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      flags <= next_flags;
      enables <= next_enables;
      program_status_word <= next_psw;
      sp <= next_sp;
      if (bus_wr & sel_edge) begin
        edge_sel <= wr_byte[3:0];
      end
      wb_ack_o <= bus_req;
      wb_dat_o <= {24'h000000, rd_byte};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer registers

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= MIC_IDLE;
      saved_psw <= `MIC_RST_BYTE;
      saved_pc <= 16'h0000;
      vec_addr <= 16'h0000;
      vec_lo <= 8'h00;
      src <= 3'h0;
      is_break <= 1'b0;
      brk_pending <= 1'b0;
      inhibit <= 1'b0;
    end else begin
      state <= next_state;
      if (state == MIC_IDLE) begin
        brk_pending <= brk_req & ~take_brk;
      end
      if (take_mask | take_brk) begin
        saved_pc <= pc_i;
        saved_psw <= take_brk ? program_status_word | 8'h10 : program_status_word & 8'hef;
        vec_addr <= next_vec; // see RULE16
        src <= win_idx;
        is_break <= take_brk;
      end
      // after a break the first boundary passes without acceptance
      if (state == MIC_A_JMP) begin
        inhibit <= is_break; // see RULE14
      end else if (instr_done_i & (state == MIC_IDLE)) begin
        inhibit <= 1'b0;
      end
      if (state == MIC_A_VH) begin
        vec_lo <= mem_rdata_i;
      end
      if (state == MIC_R_PCL) begin
        saved_psw <= mem_rdata_i;
      end
      if (state == MIC_R_PCH) begin
        saved_pc[7:0] <= mem_rdata_i;
      end
      if (state == MIC_R_CAP) begin
        saved_pc[15:8] <= mem_rdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core-facing outputs, all registered

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mem_addr_o <= 16'h0000;
      mem_wdata_o <= 8'h00;
      mem_we_o <= 1'b0;
      mem_re_o <= 1'b0;
      busy_o <= 1'b0;
      pc_load_o <= 1'b0;
      pc_o <= 16'h0000;
      psw_o <= `MIC_RST_BYTE;
    end else begin
      mem_addr_o <= next_addr;
      mem_wdata_o <= next_wdata;
      mem_we_o <= nx_push;
      mem_re_o <= nx_vec | nx_pop;
      busy_o <= (next_state != MIC_IDLE);
      pc_load_o <= (next_state == MIC_A_JMP) | (next_state == MIC_R_JMP);
      psw_o <= next_psw;
      if (state == MIC_A_CAP) begin
        pc_o <= {mem_rdata_i, vec_lo}; // see RULE16
      end else if (state == MIC_R_CAP) begin
        pc_o <= {mem_rdata_i, saved_pc[7:0]}; // see RULE19
      end
    end
  end

endmodule

`default_nettype wire

// >>> mic_mem_model.sv
`timescale 1ns/10ps
`default_nettype none

module mic_mem_model (
  // clock
  input wire logic ref_clk_i,
  // memory port from the controller
  input wire logic [15:0] mem_addr_i,
  input wire logic [7:0] mem_wdata_i,
  input wire logic mem_we_i,
  input wire logic mem_re_i,
  output logic [7:0] mem_rdata_o
);
  logic [7:0] mem [0:65535];

  // each byte holds its own low address byte, so vectors are predictable
  initial begin
    mem_rdata_o = 8'h00;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0];
    end
  end

  // sync ram, one cycle read latency
  always @(posedge ref_clk_i) begin
    if (mem_we_i) begin
      mem[mem_addr_i] <= mem_wdata_i;
    end
    // an idle bus toggles, so stale read data never looks valid
    if (mem_re_i) begin
      mem_rdata_o <= mem[mem_addr_i];
    end else begin
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule
`default_nettype wire

// >>> mic_irq_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "mic_consts.svh"

module mic_irq_ctrl_monitor (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // wishbone handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // memory port and core control
  input wire logic [15:0] mem_addr_o,
  input wire logic [7:0] mem_wdata_o,
  input wire logic mem_we_o,
  input wire logic mem_re_o,
  input wire logic busy_o,
  input wire logic pc_load_o,
  input wire logic [7:0] psw_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////
  // bus answer is one cycle late and one cycle wide
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  property p_ack1;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  // acceptance starts without a read, a return starts with one
  property p_len;
    $rose(busy_o) && !mem_re_o |-> busy_o [*8] ##1 !busy_o;
  endproperty
  property p_push;
    $rose(busy_o) && !mem_re_o |=> mem_we_o [*3] ##1 !mem_we_o;
  endproperty
  property p_page;
    mem_we_o |-> mem_addr_o[15:8] == `MIC_STACK_PAGE;
  endproperty
  property p_dec;
    mem_we_o && $past(mem_we_o) |-> mem_addr_o == $past(mem_addr_o) - 16'h1;
  endproperty
  property p_iclr;
    $rose(busy_o) && !mem_re_o && psw_o[`MIC_PSW_IFLAG] |=>
      !psw_o[`MIC_PSW_IFLAG];
  endproperty
  property p_vec;
    $rose(busy_o) && !mem_re_o |-> ##4 (mem_re_o && mem_addr_o[15:8] == 8'hff)
      ##1 (mem_re_o && mem_addr_o == $past(mem_addr_o) + 16'h1) ##2 pc_load_o;
  endproperty
  // the status word pushed just before the vector read flags a break
  property p_brk;
    mem_re_o && $past(mem_we_o) |->
      $past(mem_wdata_o[4]) == (mem_addr_o == `MIC_VEC_BREAK);
  endproperty
  property p_ret;
    $rose(busy_o) && mem_re_o |=> mem_re_o &&
      mem_addr_o == $past(mem_addr_o) + 16'h1 ##1 mem_re_o ##2 pc_load_o
      ##1 !busy_o;
  endproperty

  a_ack: assert property (p_ack) else $error("ack missing");
  a_ack1: assert property (p_ack1) else $error("ack too long");
  a_len: assert property (p_len) else $error("accept length");
  a_push: assert property (p_push) else $error("push count");
  a_page: assert property (p_page) else $error("stack page");
  a_dec: assert property (p_dec) else $error("stack order");
  a_iclr: assert property (p_iclr) else $error("enable kept");
  a_vec: assert property (p_vec) else $error("vector fetch");
  a_brk: assert property (p_brk) else $error("break flag");
  a_ret: assert property (p_ret) else $error("return pops");

  c_acc: cover property ($rose(busy_o) && !mem_re_o);
  c_ret: cover property ($rose(busy_o) && mem_re_o);
  c_brk: cover property (mem_re_o && mem_addr_o == `MIC_VEC_BREAK);
endmodule
`default_nettype wire

// >>> mic_irq_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "mic_consts.svh"

module mic_irq_ctrl_tb;
  logic ref_clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [4:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic pin0, pin1, t0, t1, ovf, conv, wd, wt, done, soft_break_instr, ret, ena;
  logic we, re, busy, pc_load;
  logic [15:0] pc_i, addr, pc_o, pc_val;
  logic [7:0] wdata, rdata, psw_o;
  logic [15:0] pcq [$];
  int n_fail = 0;
  int n_checks = 0;

  // 20 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  mic_irq_ctrl u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_irq_pin0_i(pin0),
    .ext_irq_pin1_i(pin1), .timer0_match_i(t0), .timer1_match_i(t1),
    .interval_ovf_i(ovf), .converter_done_i(conv), .watchdog_match_i(wd),
    .watch_timer_match_i(wt), .instr_done_i(done),
    .soft_break_instr_i(soft_break_instr), .irq_return_instr_i(ret),
    .irq_enable_instr_i(ena), .pc_i(pc_i), .mem_addr_o(addr),
    .mem_wdata_o(wdata), .mem_we_o(we), .mem_re_o(re),
    .mem_rdata_i(rdata), .busy_o(busy), .pc_load_o(pc_load), .pc_o(pc_o),
    .psw_o(psw_o));

  mic_mem_model u_mem (.ref_clk_i(ref_clk_i), .mem_addr_i(addr),
    .mem_wdata_i(wdata), .mem_we_i(we), .mem_re_i(re), .mem_rdata_o(rdata));

  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  // classic wishbone cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    chk("wb ack", 16'h1, 16'(wb_ack_o));
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk("register", 16'(e), 16'(q));
  endtask

  // one instruction boundary with its qualifiers
  task automatic bnd(input logic b, r, e);
    @(posedge ref_clk_i);
    pc_val = pc_val + 16'h0111;
    done <= 1'b1;
    soft_break_instr <= b;
    ret <= r;
    ena <= e;
    pc_i <= pc_val;
    @(posedge ref_clk_i);
    done <= 1'b0;
    soft_break_instr <= 1'b0;
    ret <= 1'b0;
    ena <= 1'b0;
  endtask

  task automatic wload;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pc_load !== 1'b1 && n < 20);
    chk("pc load", 16'h1, 16'(pc_load));
  endtask

  task automatic acc(input logic [15:0] v, input logic [7:0] sp, pw);
    logic [7:0] s1;
    s1 = sp - 8'h01;
    pcq.push_back(pc_val);
    wload();
    chk("entry", {v[7:0] + 8'h01, v[7:0]}, pc_o);
    chk("enable", 16'h0, 16'(psw_o[`MIC_PSW_IFLAG]));
    chk("pch", 16'(pc_val[15:8]), 16'(u_mem.mem[{8'h01, sp}]));
    chk("pcl", 16'(pc_val[7:0]), 16'(u_mem.mem[{8'h01, s1}]));
    chk("psw", 16'(pw), 16'(u_mem.mem[{8'h01, sp - 8'h2}]));
    rdc(`MIC_OFS_SP, sp - 8'h03);
  endtask

  task automatic rti(input logic ie);
    logic [15:0] p;
    p = pcq.pop_back();
    bnd(1'b0, 1'b1, 1'b0);
    wload();
    chk("return pc", p, pc_o);
    chk("restored", 16'(ie), 16'(psw_o[`MIC_PSW_IFLAG]));
  endtask

  // a boundary that must start no sequence
  task automatic idle;
    bnd(1'b0, 1'b0, 1'b0);
    repeat (2) @(posedge ref_clk_i);
    chk("busy", 16'h0, 16'(busy));
  endtask

  ////////////////////////////////////////
  task automatic s_reset;
    @(posedge ref_clk_i);
    pin0 <= 1'b1; // edges are ignored while the pin mode is off
    repeat (4) @(posedge ref_clk_i);
    for (int i = 0; i < 8; i++) begin
      rdc(5'(i * 4), (i == 6) ? `MIC_RST_SP : `MIC_RST_BYTE);
    end
    wr(5'h1c, 8'hff);
    rdc(5'h1c, 8'h00);
  endtask

  task automatic s_prio;
    logic [7:0] hi, lo;
    hi = 8'h30;
    lo = 8'hf0;
    wr(`MIC_OFS_EN_HIGH, 8'h30);
    wr(`MIC_OFS_EN_LOW, 8'h70);
    @(posedge ref_clk_i);
    {t0, t1, ovf, conv, wd, wt} <= 6'h3f;
    @(posedge ref_clk_i);
    {t0, t1, ovf, conv, wd, wt} <= 6'h00;
    rdc(`MIC_OFS_REQ_HIGH, hi);
    rdc(`MIC_OFS_REQ_LOW, lo);
    bnd(1'b0, 1'b0, 1'b1);
    for (int i = 2; i < 8; i++) begin
      if (i == 4) continue;
      bnd(1'b0, 1'b0, 1'b0);
      acc(`MIC_VEC_BASE + 16'(2 * i), 8'hff, 8'h04);
      if (i < 4) rdc(`MIC_OFS_REQ_HIGH, hi);
      else rdc(`MIC_OFS_REQ_LOW, lo);
      if (i < 4) hi[7 - i] = 1'b0;
      else lo[11 - i] = 1'b0;
      wr(`MIC_OFS_REQ_HIGH, hi);
      wr(`MIC_OFS_REQ_LOW, lo);
      rti(1'b1);
    end
    idle();
    rdc(`MIC_OFS_REQ_LOW, 8'h80);
    rdc(`MIC_OFS_SP, 8'hff);
    wr(`MIC_OFS_EN_LOW, 8'h80);
    wr(`MIC_OFS_PSW, 8'h00);
    idle();
    wr(`MIC_OFS_REQ_LOW, 8'h00);
  endtask

  task automatic s_ext;
    wr(`MIC_OFS_EDGE_SEL, {4'h0, `MIC_EDGE_RISE, `MIC_EDGE_FALL});
    @(posedge ref_clk_i);
    pin0 <= 1'b0;
    pin1 <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    rdc(`MIC_OFS_REQ_HIGH, 8'hc0);
    wr(`MIC_OFS_EN_HIGH, 8'hc0);
    wr(`MIC_OFS_PSW, 8'h04);
    bnd(1'b1, 1'b0, 1'b0);
    acc(`MIC_VEC_BASE, 8'hff, 8'h04);
    rdc(`MIC_OFS_REQ_HIGH, 8'h40);
    bnd(1'b0, 1'b0, 1'b0);
    acc(`MIC_VEC_BREAK, 8'hfc, 8'h10);
    // a break at the inhibited boundary must wait, then go next time
    bnd(1'b1, 1'b0, 1'b0);
    repeat (2) @(posedge ref_clk_i);
    chk("busy", 16'h0, 16'(busy));
    bnd(1'b0, 1'b0, 1'b0);
    acc(`MIC_VEC_BREAK, 8'hf9, 8'h10);
    rti(1'b0);
    rti(1'b0);
    rti(1'b1);
    bnd(1'b0, 1'b0, 1'b0);
    acc(`MIC_VEC_BASE + 16'h2, 8'hff, 8'h04);
    rdc(`MIC_OFS_REQ_HIGH, 8'h00);
    rti(1'b1);
    wr(`MIC_OFS_EDGE_SEL, {4'h0, `MIC_EDGE_BOTH, `MIC_EDGE_FALL});
    @(posedge ref_clk_i);
    pin0 <= 1'b1;
    pin1 <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    rdc(`MIC_OFS_REQ_HIGH, 8'h40);
  endtask

  task automatic final_report;
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // main sequence, ending with a reset in mid-run
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, pin0, pin1} = 6'h20;
    {t0, t1, ovf, conv, wd, wt, done, soft_break_instr, ret, ena} = 10'h000;
    {wb_adr_i, wb_dat_i, pc_i, pc_val} = 69'h0;
    wb_sel_i = 4'h1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    s_reset();
    s_prio();
    s_ext();
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rdc(`MIC_OFS_REQ_HIGH, `MIC_RST_BYTE);
    rdc(`MIC_OFS_EDGE_SEL, `MIC_RST_BYTE);
    final_report();
  end

  // hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    final_report();
  end
endmodule

bind mic_irq_ctrl mic_irq_ctrl_monitor u_mon (.ref_clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .mem_addr_o, .mem_wdata_o, .mem_we_o,
  .mem_re_o, .busy_o, .pc_load_o, .psw_o);
`default_nettype wire
